// File: hdl/agpm_master.sv
// How it works
// - PCI transactions interleave between pipelined data replies.
// - Start grant permits a request, not data.
// - At most four read requests outstanding.
// - Reads over 64 bytes become 32-byte requests.
// - Idle bus: enqueue requests on consecutive clocks.
// - Intervene during replies via request/grant arbitration.
// - High priority when rendering would stall.
// - Assert bus request before using the bus.
// - Arbiter grants with status code 111.
// - Start bus operation within two clocks.
// - Enqueue: address, length, command per pipe clock.
// - Pipe with request released marks last request.
// - Arbiter drops grant on pipe or frame.
// - Request held during pipe means more follow.
// - Release pipe the clock after request released.
// - Keep enqueuing until done or slots full.
// - 2X moves eight bytes per clock.
// - Strobes mark 2X data; target ready qualifies.
// - Back-to-back replies need no status change.
// - 2X writes use 1X control signalling.
// - Arbiter grants every clock for short transfers.
`include "agpm_map.svh"

module agpm_master #(
  parameter int LEN_W = 12,
  parameter int Q_DEPTH = `AGPM_Q_DEPTH
) (
  // Clock and reset.
  input logic i_mclk,
  input logic i_sys_rst,
  // Link.
  agpm_if.master bus,
  // Mode.
  input logic i_mode_2x,
  // Read requests.
  input logic i_rd_valid,
  input logic [31:0] i_rd_addr,
  input logic [LEN_W-1:0] i_rd_bytes,
  input logic i_rd_urgent,
  output logic o_rd_ready,
  // Read data.
  output logic [63:0] o_rd_data,
  output logic o_rd_wide,
  output logic o_rd_valid,
  output logic [2:0] o_outstanding,
  // Single-word PCI transactions.
  input logic i_pci_valid,
  input logic i_pci_write,
  input logic [31:0] i_pci_addr,
  input logic [31:0] i_pci_wdata,
  output logic o_pci_ready,
  output logic [31:0] o_pci_rdata,
  output logic o_pci_done
);
  import agpm_pkg::*;

  initial begin
    if (Q_DEPTH < 1 || Q_DEPTH > 4 || LEN_W < 7) begin
      $error("agpm_master: unsupported parameters");
    end
  end

  // ========================================================================
  // State
  typedef struct packed {
    agpm_mst_st_t st;
    agpm_m_in_t s1;
    agpm_m_in_t s2;
    logic clk_p;
    logic stb0_p;
    logic stb1_p;
    logic req_n;
    logic pipe_n;
    logic frame_n;
    logic irdy_n;
    logic ad_oe;
    logic [31:0] ad;
    logic [3:0] cbe;
    logic [31:0] addr;
    logic [LEN_W-1:0] rem;
    logic split;
    logic prio;
    logic rd_rdy;
    logic pci_pend;
    logic pci_rdy;
    logic pci_wr;
    logic [31:0] pci_addr;
    logic [31:0] pci_wdata;
    logic [3:0][2:0] qlen;
    logic [1:0] head;
    logic [1:0] tail;
    logic [2:0] outst;
    logic [3:0] ucnt;
    logic [63:0] rdata;
    logic rwide;
    logic rvalid;
    logic [31:0] pdata;
    logic pdone;
  } agpm_mst_t;

  agpm_mst_t q;
  agpm_mst_t n;

  function automatic logic [1:0] nxt(input logic [1:0] p);
    nxt = (p == 2'(Q_DEPTH - 1)) ? 2'h0 : p + 2'h1;
  endfunction : nxt

  // ========================================================================
  // Next state
  always_comb begin
    logic rise;
    logic inc;
    logic dec;
    logic more;
    logic [LEN_W-1:0] chunk;
    logic [LEN_W-1:0] cm1;
    logic [2:0] len;
    logic [3:0] need;
    rise = 1'b0;
    inc = 1'b0;
    dec = 1'b0;
    more = 1'b0;
    chunk = '0;
    cm1 = '0;
    len = '0;
    need = '0;
    n = q;
    n.s1 = '{clk: bus.bus_clock, gnt_n: bus.bus_grant_n, gst: bus.grant_status,
             trdy_n: bus.target_ready_n, stb0: bus.ad_strobe_0,
             stb1: bus.ad_strobe_1, ad: bus.addr_data_bus};
    n.s2 = q.s1;
    n.clk_p = q.s2.clk;
    n.stb0_p = q.s2.stb0;
    n.stb1_p = q.s2.stb1;
    n.rvalid = 1'b0;
    n.pdone = 1'b0;
    rise = q.s2.clk && !q.clk_p;

    // User requests are taken only while nothing of their kind is pending.
    if (i_rd_valid && q.rd_rdy && i_rd_bytes != '0) begin
      n.addr = i_rd_addr;
      n.rem = i_rd_bytes;
      n.split = i_rd_bytes > LEN_W'(`AGPM_SPLIT_BYTES);
      n.prio = i_rd_urgent;
    end
    if (i_pci_valid && !q.pci_pend) begin
      n.pci_pend = 1'b1;
      n.pci_wr = i_pci_write;
      n.pci_addr = i_pci_addr;
      n.pci_wdata = i_pci_wdata;
    end

    // 2X halves are caught on the strobes, not on the bus clock.
    if (q.s2.stb0 && !q.stb0_p) begin
      n.rdata[31:0] = q.s2.ad;
    end
    if (q.s2.stb1 && !q.stb1_p) begin
      n.rdata[63:32] = q.s2.ad;
    end

    if (rise) begin
      // Reply units are counted on target ready, whatever the status code.
      if (q.outst != 3'h0 && q.st != M_PADDR && q.st != M_PDATA && !q.s2.trdy_n) begin
        n.rvalid = 1'b1;
        n.rwide = i_mode_2x;
        if (!i_mode_2x) begin
          n.rdata = {32'h0000_0000, q.s2.ad};
        end
        need = i_mode_2x ? {1'b0, q.qlen[q.head]} : {q.qlen[q.head], 1'b1};
        if (q.ucnt == need) begin
          n.ucnt = 4'h0;
          n.head = nxt(q.head);
          dec = 1'b1;
        end else begin
          n.ucnt = q.ucnt + 4'h1;
        end
      end

      unique case (q.st)
        M_IDLE: begin
          if (q.pci_pend || (q.rem != '0 && q.outst < 3'(Q_DEPTH))) begin
            n.req_n = 1'b0;
            n.st = M_REQ;
          end
        end
        M_REQ, M_PIPE: begin
          if (q.st == M_REQ && !q.s2.gnt_n && q.s2.gst == `AGPM_ST_START &&
              q.pci_pend) begin
            n.req_n = 1'b1;
            n.frame_n = 1'b0;
            n.ad = q.pci_addr;
            n.ad_oe = 1'b1;
            n.cbe = q.pci_wr ? `AGPM_CMD_MEM_WR : `AGPM_CMD_MEM_RD;
            n.st = M_PADDR;
          end else if (q.st == M_PIPE ||
                       (!q.s2.gnt_n && q.s2.gst == `AGPM_ST_START)) begin
            chunk = (q.split && q.rem > LEN_W'(`AGPM_CHUNK_BYTES)) ?
                    LEN_W'(`AGPM_CHUNK_BYTES) : q.rem;
            cm1 = chunk - LEN_W'(1);
            len = cm1[`AGPM_QW_SHIFT +: `AGPM_LEN_W];
            n.pipe_n = 1'b0;
            n.ad = {q.addr[31:`AGPM_LEN_W], len};
            n.ad_oe = 1'b1;
            n.cbe = q.prio ? `AGPM_CMD_RD_HI : `AGPM_CMD_RD_LO;
            n.qlen[q.tail] = len;
            n.tail = nxt(q.tail);
            inc = 1'b1;
            n.rem = q.rem - chunk;
            n.addr = q.addr + 32'(chunk);
            more = n.rem != '0 && (q.outst + 3'h1) < 3'(Q_DEPTH);
            n.req_n = !more;
            n.st = more ? M_PIPE : M_LAST;
          end
        end
        M_LAST: begin
          n.pipe_n = 1'b1;
          n.ad_oe = 1'b0;
          n.st = M_IDLE;
        end
        M_PADDR: begin
          n.frame_n = 1'b1;
          n.irdy_n = 1'b0;
          n.cbe = `AGPM_BE_ALL;
          n.ad = q.pci_wdata;
          n.ad_oe = q.pci_wr;
          n.st = M_PDATA;
        end
        M_PDATA: begin
          if (!q.s2.trdy_n) begin
            n.irdy_n = 1'b1;
            n.ad_oe = 1'b0;
            n.pdata = q.s2.ad;
            n.pdone = 1'b1;
            n.pci_pend = 1'b0;
            n.st = M_IDLE;
          end
        end
      endcase
    end

    n.outst = q.outst + 3'(inc) - 3'(dec);
    n.rd_rdy = n.rem == '0;
    n.pci_rdy = !n.pci_pend;
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      q <= '0;
      q.req_n <= 1'b1;
      q.pipe_n <= 1'b1;
      q.frame_n <= 1'b1;
      q.irdy_n <= 1'b1;
      q.rd_rdy <= 1'b1;
      q.pci_rdy <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // ========================================================================
  // Outputs
  assign bus.bus_request_n = q.req_n;
  assign bus.pipe_enqueue_n = q.pipe_n;
  assign bus.frame_n = q.frame_n;
  assign bus.initiator_ready_n = q.irdy_n;
  assign bus.cmd_byte_enable = q.cbe;
  assign bus.ad_m_out = q.ad;
  assign bus.ad_m_oe = q.ad_oe;
  assign o_rd_ready = q.rd_rdy;
  assign o_rd_data = q.rdata;
  assign o_rd_wide = q.rwide;
  assign o_rd_valid = q.rvalid;
  assign o_outstanding = q.outst;
  assign o_pci_ready = q.pci_rdy;
  assign o_pci_rdata = q.pdata;
  assign o_pci_done = q.pdone;

endmodule : agpm_master

// File: include/agpm_map.svh
`ifndef AGPM_MAP_SVH
`define AGPM_MAP_SVH

// ==========================================================================
// Link codes
`define AGPM_ST_START 3'h7
`define AGPM_ST_RD_LO 3'h0
`define AGPM_ST_RD_HI 3'h1
`define AGPM_CMD_RD_LO 4'h0
`define AGPM_CMD_RD_HI 4'h4
`define AGPM_CMD_MEM_RD 4'h6
`define AGPM_CMD_MEM_WR 4'h7
`define AGPM_BE_ALL 4'h0

// ==========================================================================
// Request layout and sizes
`define AGPM_LEN_W 3
`define AGPM_QW_SHIFT 3
`define AGPM_SPLIT_BYTES 64
`define AGPM_CHUNK_BYTES 32
`define AGPM_Q_DEPTH 4

// ==========================================================================
// Timing
`define AGPM_MCLK_NS 10
`define AGPM_BUS_PERIOD_NS 160
`define AGPM_BUS_HALF (`AGPM_BUS_PERIOD_NS / (2 * `AGPM_MCLK_NS))

`endif

// File: include/agpm_pkg.sv
package agpm_pkg;

  typedef enum logic [2:0] {M_IDLE, M_REQ, M_PIPE, M_LAST, M_PADDR, M_PDATA} agpm_mst_st_t;
  typedef enum logic [2:0] {B_IDLE, B_GRANT, B_PIPE, B_TGT, B_TDATA} agpm_brg_st_t;

  // Link signals as the master end samples them.
  typedef struct packed {
    logic clk;
    logic gnt_n;
    logic [2:0] gst;
    logic trdy_n;
    logic stb0;
    logic stb1;
    logic [31:0] ad;
  } agpm_m_in_t;

  // Link signals as the bridge end samples them.
  typedef struct packed {
    logic req_n;
    logic pipe_n;
    logic frame_n;
    logic irdy_n;
    logic [3:0] cbe;
    logic [31:0] ad;
  } agpm_b_in_t;

endpackage : agpm_pkg

// File: include/agpm_if.sv
interface agpm_if;
  logic bus_clock;
  logic bus_request_n;
  logic bus_grant_n;
  logic [2:0] grant_status;
  logic pipe_enqueue_n;
  logic frame_n;
  logic initiator_ready_n;
  logic target_ready_n;
  logic [3:0] cmd_byte_enable;
  logic ad_strobe_0;
  logic ad_strobe_1;
  logic [31:0] ad_m_out;
  logic ad_m_oe;
  logic [31:0] ad_b_out;
  logic ad_b_oe;
  logic [31:0] addr_data_bus;

  // The shared bus floats high when neither end drives it.
  assign addr_data_bus = ad_m_oe ? ad_m_out : (ad_b_oe ? ad_b_out : '1);

  modport master (
    input bus_clock, bus_grant_n, grant_status, target_ready_n,
    input ad_strobe_0, ad_strobe_1, addr_data_bus,
    output bus_request_n, pipe_enqueue_n, frame_n, initiator_ready_n,
    output cmd_byte_enable, ad_m_out, ad_m_oe
  );

  modport bridge (
    input bus_request_n, pipe_enqueue_n, frame_n, initiator_ready_n,
    input cmd_byte_enable, addr_data_bus,
    output bus_clock, bus_grant_n, grant_status, target_ready_n,
    output ad_strobe_0, ad_strobe_1, ad_b_out, ad_b_oe
  );
endinterface : agpm_if

// File: hdl/agpm_bridge.sv
`include "agpm_map.svh"

module agpm_bridge #(
  parameter int HALF = `AGPM_BUS_HALF,
  parameter int Q_DEPTH = `AGPM_Q_DEPTH
) (
  // Clock and reset.
  input logic i_mclk,
  input logic i_sys_rst,
  // Link.
  agpm_if.bridge bus,
  // Mode.
  input logic i_mode_2x,
  // Memory read port, answered combinationally.
  output logic [31:0] o_mem_addr,
  input logic [63:0] i_mem_data,
  output logic o_enq,
  // PCI target.
  output logic o_pci_valid,
  output logic o_pci_write,
  output logic [31:0] o_pci_addr,
  output logic [31:0] o_pci_wdata,
  input logic [31:0] i_pci_rdata
);
  import agpm_pkg::*;

  localparam int PH_W = $clog2(2 * HALF);

  initial begin
    if (HALF < 4 || Q_DEPTH < 1 || Q_DEPTH > 4) begin
      $error("agpm_bridge: unsupported parameters");
    end
  end

  // ========================================================================
  // State
  typedef struct packed {
    agpm_brg_st_t st;
    logic [PH_W-1:0] ph;
    logic bclk;
    agpm_b_in_t s1;
    agpm_b_in_t s2;
    agpm_b_in_t smp;
    logic gnt_n;
    logic [2:0] gst;
    logic trdy_n;
    logic stb0;
    logic stb1;
    logic rep;
    logic [31:0] ad;
    logic [31:0] hi32;
    logic ad_oe;
    logic [3:0][28:0] qaddr;
    logic [3:0][2:0] qlen;
    logic [3:0] qhi;
    logic [1:0] head;
    logic [1:0] tail;
    logic [2:0] cnt;
    logic [3:0] ucnt;
    logic [31:0] mem_addr;
    logic enq;
    logic pv;
    logic pwr;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } agpm_brg_t;

  agpm_brg_t q;
  agpm_brg_t n;

  function automatic logic [1:0] nxt(input logic [1:0] p);
    nxt = (p == 2'(Q_DEPTH - 1)) ? 2'h0 : p + 2'h1;
  endfunction : nxt

  // ========================================================================
  // Next state
  always_comb begin
    logic inc;
    logic dec;
    logic [3:0] need;
    logic [3:0] qw;
    inc = 1'b0;
    dec = 1'b0;
    need = '0;
    qw = '0;
    n = q;
    n.s1 = '{req_n: bus.bus_request_n, pipe_n: bus.pipe_enqueue_n,
             frame_n: bus.frame_n, irdy_n: bus.initiator_ready_n,
             cbe: bus.cmd_byte_enable, ad: bus.addr_data_bus};
    n.s2 = q.s1;
    n.enq = 1'b0;
    n.pv = 1'b0;
    n.ph = (q.ph == PH_W'(2 * HALF - 1)) ? '0 : q.ph + PH_W'(1);
    n.bclk = n.ph < PH_W'(HALF);
    if (q.ph == '0) begin
      n.smp = q.s2;
    end
    if (q.rep && q.ph == PH_W'(HALF + 1)) begin
      n.stb0 = 1'b1;
    end
    if (q.rep && q.ph == PH_W'(HALF + HALF / 2)) begin
      n.ad = q.hi32;
      n.stb1 = 1'b1;
    end

    // Outputs change on the falling edge; link inputs were taken at the rise.
    if (q.ph == PH_W'(HALF)) begin
      n.gnt_n = 1'b1;
      n.trdy_n = 1'b1;
      n.stb0 = 1'b0;
      n.stb1 = 1'b0;
      n.rep = 1'b0;
      n.ad_oe = 1'b0;
      if (!q.smp.pipe_n && q.cnt < 3'(Q_DEPTH)) begin
        n.qaddr[q.tail] = q.smp.ad[31:`AGPM_LEN_W];
        n.qlen[q.tail] = q.smp.ad[`AGPM_LEN_W-1:0];
        n.qhi[q.tail] = q.smp.cbe == `AGPM_CMD_RD_HI;
        n.tail = nxt(q.tail);
        n.enq = 1'b1;
        inc = 1'b1;
      end
      unique case (q.st)
        B_IDLE: begin
          if (!q.smp.req_n) begin
            n.gnt_n = 1'b0;
            n.gst = `AGPM_ST_START;
            n.st = B_GRANT;
          end else if (q.cnt != 3'h0) begin
            n.gnt_n = 1'b0;
            n.gst = q.qhi[q.head] ? `AGPM_ST_RD_HI : `AGPM_ST_RD_LO;
            n.trdy_n = 1'b0;
            n.ad_oe = 1'b1;
            n.rep = i_mode_2x;
            n.hi32 = i_mem_data[63:32];
            n.ad = (!i_mode_2x && q.ucnt[0]) ? i_mem_data[63:32] : i_mem_data[31:0];
            need = i_mode_2x ? {1'b0, q.qlen[q.head]} : {q.qlen[q.head], 1'b1};
            if (q.ucnt == need) begin
              n.ucnt = 4'h0;
              n.head = nxt(q.head);
              dec = 1'b1;
            end else begin
              n.ucnt = q.ucnt + 4'h1;
            end
          end
        end
        B_GRANT: begin
          if (!q.smp.pipe_n) begin
            n.st = q.smp.req_n ? B_IDLE : B_PIPE;
          end else if (!q.smp.frame_n) begin
            n.pv = 1'b1;
            n.pwr = q.smp.cbe == `AGPM_CMD_MEM_WR;
            n.paddr = q.smp.ad;
            n.st = B_TGT;
          end else begin
            n.gnt_n = 1'b0;
            n.gst = `AGPM_ST_START;
          end
        end
        B_PIPE: begin
          if (q.smp.pipe_n || q.smp.req_n) begin
            n.st = B_IDLE;
          end
        end
        B_TGT: begin
          if (!q.smp.irdy_n) begin
            n.trdy_n = 1'b0;
            n.ad = i_pci_rdata;
            n.ad_oe = !q.pwr;
            n.pwdata = q.smp.ad;
            n.st = B_TDATA;
          end
        end
        B_TDATA: begin
          n.st = B_IDLE;
        end
      endcase
    end

    n.cnt = q.cnt + 3'(inc) - 3'(dec);
    qw = i_mode_2x ? n.ucnt : {1'b0, n.ucnt[3:1]};
    n.mem_addr = {n.qaddr[n.head], 3'h0} + {25'h0000000, qw, 3'h0};
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      q <= '0;
      q.gnt_n <= 1'b1;
      q.trdy_n <= 1'b1;
      q.s1 <= '1;
      q.s2 <= '1;
      q.smp <= '1;
    end else begin
      q <= n;
    end
  end

  // ========================================================================
  // Outputs
  assign bus.bus_clock = q.bclk;
  assign bus.bus_grant_n = q.gnt_n;
  assign bus.grant_status = q.gst;
  assign bus.target_ready_n = q.trdy_n;
  assign bus.ad_strobe_0 = q.stb0;
  assign bus.ad_strobe_1 = q.stb1;
  assign bus.ad_b_out = q.ad;
  assign bus.ad_b_oe = q.ad_oe;
  assign o_mem_addr = q.mem_addr;
  assign o_enq = q.enq;
  assign o_pci_valid = q.pv;
  assign o_pci_write = q.pwr;
  assign o_pci_addr = q.paddr;
  assign o_pci_wdata = q.pwdata;

endmodule : agpm_bridge

// File: verif/agpm_monitor.sv
module agpm_monitor (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Link signals.
  input wire logic bus_clock,
  input wire logic bus_request_n,
  input wire logic bus_grant_n,
  input wire logic [2:0] grant_status,
  input wire logic pipe_enqueue_n,
  input wire logic frame_n,
  input wire logic initiator_ready_n,
  input wire logic [3:0] cmd_byte_enable,
  input wire logic ad_m_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Link sequences
  default clocking cb @(posedge bus_clock);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_start;
    !bus_grant_n && grant_status == 3'h7;
  endsequence

  sequence s_enq;
    !pipe_enqueue_n || !frame_n;
  endsequence

  property p_reset_idle;
    @(posedge i_mclk) disable iff (i_sys_rst)
      $fell(i_sys_rst) |-> bus_request_n && pipe_enqueue_n && frame_n && !ad_m_oe;
  endproperty

  // ==========================================================================
  // Checks
  reset_idle_a: assert property (p_reset_idle)
    else $error("link outputs busy after reset");
  start_grant_a: assert property ($fell(bus_request_n) |-> ##[1:4] s_start)
    else $error("no start grant after request");
  start_act_a: assert property ($fell(bus_grant_n) && grant_status == 3'h7 |->
    ##[1:2] s_enq)
    else $error("no bus operation after start");
  req_before_a: assert property ($fell(pipe_enqueue_n) || $fell(frame_n) |->
    !$past(bus_request_n))
    else $error("bus used without request");
  last_drop_a: assert property (!pipe_enqueue_n && bus_request_n |=> pipe_enqueue_n)
    else $error("pipe held after last request");
  more_follow_a: assert property (!pipe_enqueue_n && !bus_request_n |=> !pipe_enqueue_n)
    else $error("pipe dropped while more announced");
  enq_fields_a: assert property (!pipe_enqueue_n |->
    frame_n && ad_m_oe && cmd_byte_enable inside {4'h0, 4'h4})
    else $error("bad enqueue cycle");
  frame_cmd_a: assert property ($fell(frame_n) |->
    ad_m_oe && cmd_byte_enable inside {4'h6, 4'h7} ##1 !initiator_ready_n && frame_n)
    else $error("bad single word transaction");
  grant_drop_a: assert property (s_enq |=> bus_grant_n)
    else $error("grant kept after pipe or frame");
endmodule : agpm_monitor

// File: verif/agp_master_request_pipeline_bench.sv
module agp_master_request_pipeline_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic mode_2x = 1'b0;
  logic rd_valid = 1'b0;
  logic [31:0] rd_addr = 32'h0;
  logic [11:0] rd_bytes = 12'h0;
  logic rd_urgent = 1'b0;
  logic pci_valid = 1'b0;
  logic pci_write = 1'b0;
  logic [31:0] pci_addr = 32'h0;
  logic [31:0] pci_wdata = 32'h0;
  logic rd_ready, rd_wide, rd_vld, pci_ready, pci_done, b_valid, b_write, half, cap_wr;
  logic [63:0] rd_data;
  logic [2:0] outst, last_len;
  logic [3:0] last_cmd;
  logic [31:0] m_rdata, mem_addr, b_addr, b_wdata, exp_q, cap_addr;
  int err_count = 0;
  int tests_run = 0;
  int units, enqs, max_out;

  agpm_if bus_if ();
  agpm_master u_agpm_master (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .bus(bus_if.master),
    .i_mode_2x(mode_2x), .i_rd_valid(rd_valid), .i_rd_addr(rd_addr), .i_rd_bytes(rd_bytes),
    .i_rd_urgent(rd_urgent), .o_rd_ready(rd_ready), .o_rd_data(rd_data), .o_rd_wide(rd_wide),
    .o_rd_valid(rd_vld), .o_outstanding(outst), .i_pci_valid(pci_valid),
    .i_pci_write(pci_write), .i_pci_addr(pci_addr), .i_pci_wdata(pci_wdata),
    .o_pci_ready(pci_ready), .o_pci_rdata(m_rdata), .o_pci_done(pci_done));
  agpm_bridge u_agpm_bridge (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .bus(bus_if.bridge),
    .i_mode_2x(mode_2x), .o_mem_addr(mem_addr), .i_mem_data({mem_addr ^ 32'hFFFF0000, mem_addr}),
    .o_enq(), .o_pci_valid(b_valid), .o_pci_write(b_write), .o_pci_addr(b_addr),
    .o_pci_wdata(b_wdata), .i_pci_rdata(b_addr ^ 32'hA5A5A5A5));
  agpm_monitor u_agpm_monitor (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .bus_clock(bus_if.bus_clock), .bus_request_n(bus_if.bus_request_n),
    .bus_grant_n(bus_if.bus_grant_n), .grant_status(bus_if.grant_status),
    .pipe_enqueue_n(bus_if.pipe_enqueue_n), .frame_n(bus_if.frame_n),
    .initiator_ready_n(bus_if.initiator_ready_n), .cmd_byte_enable(bus_if.cmd_byte_enable),
    .ad_m_oe(bus_if.ad_m_oe));

  initial begin
    forever #5 i_mclk = ~i_mclk;
  end

  // ==========================================================================
  // Observers
  always @(posedge bus_if.bus_clock) begin
    if (!bus_if.pipe_enqueue_n) begin
      enqs++;
      last_cmd = bus_if.cmd_byte_enable;
      last_len = bus_if.addr_data_bus[2:0];
    end
  end

  always @(posedge i_mclk) begin
    if (b_valid) begin
      cap_addr = b_addr;
      cap_wr = b_write;
    end
    if (outst > max_out) max_out = outst;
    if (rd_vld) begin
      units++;
      if (mode_2x) begin
        chk("rd_qword", {rd_wide, rd_data}, {1'b1, exp_q ^ 32'hFFFF0000, exp_q});
        exp_q += 32'h8;
      end else begin
        chk("rd_dword", {rd_wide, rd_data},
            {1'b0, 32'h0000_0000, half ? exp_q ^ 32'hFFFF0000 : exp_q});
        if (half) exp_q += 32'h8;
        half = ~half;
      end
    end
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input string name, input logic [95:0] seen, input logic [95:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  task automatic rd_start(input logic [31:0] a, input logic [11:0] n, input logic u);
    @(negedge i_mclk);
    rd_addr = a;
    rd_bytes = n;
    rd_urgent = u;
    rd_valid = 1'b1;
    exp_q = a;
    half = 1'b0;
    units = 0;
    enqs = 0;
    max_out = 0;
    @(negedge i_mclk);
    rd_valid = 1'b0;
  endtask : rd_start

  task automatic rd_wait(input int n);
    int i;
    for (i = 0; i < 20000 && units < n; i++) @(negedge i_mclk);
    for (i = 0; i < 2000 && outst != 3'h0; i++) @(negedge i_mclk);
    chk("rd_units", units, n);
  endtask : rd_wait

  task automatic pci_op(input logic w, input logic [31:0] a, input logic [31:0] d);
    int i;
    @(negedge i_mclk);
    pci_valid = 1'b1;
    pci_write = w;
    pci_addr = a;
    pci_wdata = d;
    @(negedge i_mclk);
    pci_valid = 1'b0;
    for (i = 0; i < 4000 && pci_done !== 1'b1; i++) @(negedge i_mclk);
    chk("pci_target", {cap_wr, cap_addr}, {w, a});
    chk("pci_data", w ? b_wdata : m_rdata, w ? d : a ^ 32'hA5A5A5A5);
  endtask : pci_op

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    chk("idle", {rd_ready, pci_ready, outst, bus_if.bus_request_n}, {1'b1, 1'b1, 3'h0, 1'b1});
    $display("t_reset done");
  endtask : t_reset

  task automatic t_read_1x();
    rd_start(32'h00100040, 12'd40, 1'b0);
    rd_wait(10);
    chk("enq_fields", {enqs, last_cmd, last_len}, {32'd1, 4'h0, 3'h4});
    $display("t_read_1x done");
  endtask : t_read_1x

  task automatic t_read_mixed();
    int i;
    rd_start(32'h00200000, 12'd64, 1'b0);
    for (i = 0; i < 4000 && units < 1; i++) @(negedge i_mclk);
    pci_op(1'b1, 32'h40001000, 32'h12345678);
    rd_wait(16);
    chk("enq_fields", {enqs, last_len}, {32'd1, 3'h7});
    $display("t_read_mixed done");
  endtask : t_read_mixed

  task automatic t_pci();
    pci_op(1'b0, 32'h40002004, 32'h0);
    mode_2x = 1'b1;
    pci_op(1'b1, 32'h40003008, 32'h9ABCDEF0);
    $display("t_pci done");
  endtask : t_pci

  task automatic t_read_split();
    rd_start(32'h20000100, 12'd128, 1'b1);
    rd_wait(16);
    chk("enq_fields", {enqs, last_cmd, last_len}, {32'd4, 4'h4, 3'h3});
    chk("queue_depth", max_out <= 4, 1'b1);
    rd_start(32'h03000008, 12'd72, 1'b0);
    rd_wait(9);
    chk("enq_fields", {enqs, last_cmd, last_len}, {32'd3, 4'h0, 3'h0});
    $display("t_read_split done");
  endtask : t_read_split

  // ==========================================================================
  // Run control
  task automatic conclude();
    $display("tests_run %0d err_count %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  initial begin
    #300000;
    err_count++;
    conclude();
  end

  initial begin
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk);
    i_sys_rst = 1'b0;
    t_reset();
    t_read_1x();
    t_read_mixed();
    t_pci();
    t_read_split();
    conclude();
  end
endmodule : agp_master_request_pipeline_bench
